// >>> rtl/ldcp_pkg.sv
// constants for the low-latency dram command port
// assumes a core clock of 50 MHz and a separate write strobe clock domain
package ldcp_pkg;
    localparam int CORE_CLK_MHZ       = 50;
    localparam int CORE_PERIOD_PS     = 1000000 / CORE_CLK_MHZ;
    // clock static time before pll reset, ns
    localparam int CLK_STATIC_NS      = 30;
    // longest time rounds down, at least one cycle
    localparam int CLK_STATIC_CYC     = (CLK_STATIC_NS * 1000 / CORE_PERIOD_PS)
                                        < 1 ? 1 :
                                        (CLK_STATIC_NS * 1000 / CORE_PERIOD_PS);
    // pll lock time, us; least time rounds up
    localparam int PLL_LOCK_US        = 15;
    localparam int PLL_LOCK_CYC       = (PLL_LOCK_US * 1000000 + CORE_PERIOD_PS
                                        - 1) / CORE_PERIOD_PS;
    localparam int MODE_LOAD_GAP_CYC  = 6;
    localparam int ADDR_W             = 21;
    localparam int OPCODE_W           = 18;
    localparam int BANK_W             = 3;
    localparam int HALF_W             = 9;
    localparam logic [1:0] BL_RESET   = 2'h0;

    typedef enum logic [2:0] {
        LDCP_IDLE,
        LDCP_MODE_LOAD,
        LDCP_READ,
        LDCP_WRITE,
        LDCP_RECHARGE
    } ldcp_cmd_type;

    // burst code 0/1/2 = bl 2/4/8; one address bit fewer each doubling
    function automatic logic [4:0] ldcp_top_bit(input logic [1:0] bl,
                                                input logic       wide);
        logic [4:0] base;
        base = wide ? 5'h13 : 5'h14;
        ldcp_top_bit = base - {3'h0, bl};
    endfunction : ldcp_top_bit
endpackage : ldcp_pkg

// >>> rtl/ldcp_command_port.sv
// command decode, mode load, pll watch and data strobing of the port
// assumes main clock sampled as core_clk_i; write data on its own clock
// assumes the enable reaches the write side only while its strobe runs
//
// Operation
// R1: command and address sampled only on the main clock rising edge.
// R2: controller never drives command codes outside the defined set.
// R3: chip select high decodes idle; strobes, address, bank ignored.
// R4: all three low decodes mode load; opcode from address, bank ignored.
// R5: mode load opcode uses address bits zero to seventeen only.
// R6: strobes select read, write or recharge, each with bank select.
// R7: meaningful address bits shrink by one as burst length doubles.
// R8: controller waits six cycles after a mode load.
// R9: clock static 30 ns resets pll; 15 us toggling relocks it.
// R10: controller keeps clock period within the allowed range.
// R11: controller keeps the clock frequency constant.
// R12: write data and mask captured on the write strobe clock.
// R13: wide mode splits read data across two read strobe clocks.
// R14: controller waits bank cycle time after recharge to same bank.
// R15: controller loads mode only with banks idle and no bursts.
// R16: write beats with mask low stored, mask high dropped.
// R17: idle never disturbs operations in progress; no commands taken.
// R18: controller drives only meaningful address bits, upper bits low.
// R19: controller drives idle whenever no other command is issued.
`timescale 1ns/1ns
module ldcp_command_port #(
    parameter int WIDE          = 1,
    parameter int PLL_LOCK_CYCS = ldcp_pkg::PLL_LOCK_CYC
) (
    // core clock, reset, enable
    input  wire logic                        core_clk_i,
    input  wire logic                        rst_b_i,
    input  wire logic                        clk_en_i,
    // command pins, sampled on the main clock
    input  wire logic                        cs_b_i,
    input  wire logic                        we_b_i,
    input  wire logic                        recharge_b_i,
    input  wire logic [ldcp_pkg::ADDR_W-1:0] address_bus_i,
    input  wire logic [ldcp_pkg::BANK_W-1:0] bank_select_i,
    // main clock activity from outside, a level to synchronise
    input  wire logic                        main_clock_pair_i,
    // write strobe clock domain
    input  wire logic                        write_strobe_clock_i,
    input  wire logic [2*ldcp_pkg::HALF_W-1:0] wr_data_i,
    input  wire logic                        write_byte_mask_i,
    input  wire logic                        wr_beat_i,
    // read data to launch
    input  wire logic [2*ldcp_pkg::HALF_W-1:0] rd_data_i,
    // decoded command
    output logic [2:0]                       cmd_o,
    output logic [ldcp_pkg::BANK_W-1:0]      cmd_bank_o,
    output logic [ldcp_pkg::ADDR_W-1:0]      cmd_addr_o,
    output logic [ldcp_pkg::OPCODE_W-1:0]    mode_opcode_o,
    output logic [1:0]                       burst_code_o,
    output logic                             pll_locked_o,
    output logic                             mode_busy_o,
    // write side outputs, core domain
    output logic [2*ldcp_pkg::HALF_W-1:0]    wr_store_data_o,
    output logic                             wr_store_o,
    // read launch per strobe
    output logic [ldcp_pkg::HALF_W-1:0]      rd_lane0_o,
    output logic [ldcp_pkg::HALF_W-1:0]      rd_lane1_o
);
    ldcp_pkg::ldcp_cmd_type cmd_d, cmd_q;

    // pin synchronisers: two flops before any logic
    logic [1:0] cs_s, we_s, rc_s, ck_s;
    logic [ldcp_pkg::ADDR_W-1:0] a_s1, a_s2;
    logic [ldcp_pkg::BANK_W-1:0] b_s1, b_s2;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cs_s <= 2'h3;
            we_s <= 2'h3;
            rc_s <= 2'h3;
            ck_s <= 2'h0;
            a_s1 <= '0;
            a_s2 <= '0;
            b_s1 <= '0;
            b_s2 <= '0;
        end else if (clk_en_i) begin
            cs_s <= {cs_s[0], cs_b_i};
            we_s <= {we_s[0], we_b_i};
            rc_s <= {rc_s[0], recharge_b_i};
            ck_s <= {ck_s[0], main_clock_pair_i};
            a_s1 <= address_bus_i;
            a_s2 <= a_s1;
            b_s1 <= bank_select_i;
            b_s2 <= b_s1;
        end
    end

    wire cs_n = cs_s[1];
    wire we_n = we_s[1];
    wire rc_n = rc_s[1];

    // decode on sampled edge only; idle when deselected
    assign cmd_d = cs_n ? ldcp_pkg::LDCP_IDLE :            // see R1 R3 R17
                   (!we_n && !rc_n) ? ldcp_pkg::LDCP_MODE_LOAD :  // see R4
                   ( we_n &&  rc_n) ? ldcp_pkg::LDCP_READ :       // see R6
                   (!we_n &&  rc_n) ? ldcp_pkg::LDCP_WRITE :      // see R6
                   ldcp_pkg::LDCP_RECHARGE;                       // see R6

    wire is_ml = (cmd_d == ldcp_pkg::LDCP_MODE_LOAD);
    wire uses_bank = (cmd_d != ldcp_pkg::LDCP_IDLE) && !is_ml;

    // address mask by burst length; wide parts lose one more bit
    logic [1:0] bl_q;
    wire [4:0] top = ldcp_pkg::ldcp_top_bit(bl_q, WIDE != 0);      // see R7
    wire [ldcp_pkg::ADDR_W-1:0] amask =
        ldcp_pkg::ADDR_W'((22'h1 << (top + 5'h1)) - 22'h1);
    wire is_rw = (cmd_d == ldcp_pkg::LDCP_READ) ||
                 (cmd_d == ldcp_pkg::LDCP_WRITE);

    // mode load gap counter; status only, gap is the controller's duty
    logic [2:0] gap_q;
    wire [2:0] gap_d = is_ml ? 3'(ldcp_pkg::MODE_LOAD_GAP_CYC) :
                       (gap_q != 3'h0) ? gap_q - 3'h1 : 3'h0;   // see R8

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmd_q         <= ldcp_pkg::LDCP_IDLE;
            cmd_bank_o    <= '0;
            cmd_addr_o    <= '0;
            mode_opcode_o <= '0;
            bl_q          <= ldcp_pkg::BL_RESET;
            gap_q         <= 3'h0;
        end else if (clk_en_i) begin
            cmd_q <= cmd_d;
            gap_q <= gap_d;
            if (uses_bank)
                cmd_bank_o <= b_s2;                        // see R6
            if (is_rw)
                cmd_addr_o <= a_s2 & amask;                // see R7
            if (is_ml) begin
                // only low opcode bits kept
                mode_opcode_o <= a_s2[ldcp_pkg::OPCODE_W-1:0]; // see R4 R5
                // burst field in low bits; illegal code kept at bl 8
                bl_q <= (a_s2[4:3] == 2'h3) ? 2'h2 : a_s2[4:3];
            end
        end
    end
    assign cmd_o        = cmd_q;
    assign burst_code_o = bl_q;
    assign mode_busy_o  = (gap_q != 3'h0);

    // pll watch: static clock resets lock, toggling relocks
    logic [$clog2(PLL_LOCK_CYCS+1)-1:0] lock_q;
    logic [5:0] stat_q;
    logic       ck_prev_q;
    wire  ck_tog = ck_s[1] ^ ck_prev_q;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ck_prev_q    <= 1'b0;
            stat_q       <= 6'h0;
            lock_q       <= '0;
            pll_locked_o <= 1'b0;
        end else if (clk_en_i) begin
            ck_prev_q <= ck_s[1];
            stat_q <= ck_tog ? 6'h0 :
                      (stat_q == 6'h3F) ? stat_q : stat_q + 6'h1;
            if (!ck_tog && stat_q >= 6'(ldcp_pkg::CLK_STATIC_CYC - 1)) begin
                lock_q       <= '0;                        // see R9
                pll_locked_o <= 1'b0;
            end else if (lock_q == ($bits(lock_q))'(PLL_LOCK_CYCS)) begin
                pll_locked_o <= 1'b1;                      // see R9
            end else begin
                lock_q <= lock_q + 1'b1;
            end
        end
    end

    // enable into the strobe domain; resets enabled so no beat is lost
    logic [1:0] wen_s;
    always_ff @(posedge write_strobe_clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wen_s <= 2'h3;
        end else begin
            wen_s <= {wen_s[0], clk_en_i};
        end
    end

    // write strobe domain capture; masked beats never flagged
    logic [2*ldcp_pkg::HALF_W-1:0] wdat_q;
    logic                          wtog_q;
    always_ff @(posedge write_strobe_clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wdat_q <= '0;
            wtog_q <= 1'b0;
        end else if (wen_s[1] && wr_beat_i && !write_byte_mask_i) begin
            wdat_q <= wr_data_i;                           // see R12 R16
            wtog_q <= ~wtog_q;
        end
    end

    // toggle crossing; data held stable until next beat
    logic [2:0] wt_s;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wt_s            <= 3'h0;
            wr_store_o      <= 1'b0;
            wr_store_data_o <= '0;
        end else if (clk_en_i) begin
            wt_s       <= {wt_s[1:0], wtog_q};
            wr_store_o <= wt_s[2] ^ wt_s[1];               // see R16
            if (wt_s[2] ^ wt_s[1])
                wr_store_data_o <= wdat_q;                 // see R12
        end
    end

    // read lanes: wide splits across two strobes, narrow on first only
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_lane0_o <= '0;
            rd_lane1_o <= '0;
        end else if (clk_en_i) begin
            rd_lane0_o <= rd_data_i[ldcp_pkg::HALF_W-1:0];     // see R13
            rd_lane1_o <= (WIDE != 0) ?
                rd_data_i[2*ldcp_pkg::HALF_W-1:ldcp_pkg::HALF_W] :
                '0;                                            // see R13
        end
    end
endmodule : ldcp_command_port

// >>> dv/ldcp_checker_assertions.sv
// checker: command decode, mode gap and address masking of the port
// assumes clk_en_i held high; pins reach decode three edges later
`timescale 1ns/1ns
module ldcp_checker #(parameter int WIDE = 1) (
    input wire logic        core_clk_i, rst_b_i, cs_b_i, we_b_i,
    input wire logic        recharge_b_i, mode_busy_o, wr_store_o,
    input wire logic        pll_locked_o,
    input wire logic [20:0] address_bus_i, cmd_addr_o,
    input wire logic [2:0]  bank_select_i, cmd_o, cmd_bank_o,
    input wire logic [17:0] mode_opcode_o,
    input wire logic [1:0]  burst_code_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    wire [1:0]  strb_w = {we_b_i, recharge_b_i};
    wire [17:0] op_w   = address_bus_i[17:0];
    // code 3 counts as the longest burst
    wire [4:0]  cut_w  = (WIDE != 0 ? 5'h14 : 5'h15) -
                         {3'h0, burst_code_o[1] ? 2'h2 : burst_code_o};
    a_desel_idle: assert property (cs_b_i
        |-> ##3 cmd_o == 3'h0) else $error("deselect decoded as a command");
    a_mode_load: assert property (!cs_b_i && strb_w == 2'h0
        |-> ##3 cmd_o == 3'h1 && mode_opcode_o == $past(op_w, 3))
        else $error("mode load decode or opcode wrong");
    a_read_dec: assert property (!cs_b_i && strb_w == 2'h3
        |-> ##3 cmd_o == 3'h2 && cmd_bank_o == $past(bank_select_i, 3))
        else $error("read decode or bank wrong");
    a_write_dec: assert property (!cs_b_i && strb_w == 2'h1
        |-> ##3 cmd_o == 3'h3 && cmd_bank_o == $past(bank_select_i, 3))
        else $error("write decode or bank wrong");
    a_recharge_dec: assert property (!cs_b_i && strb_w == 2'h2
        |-> ##3 cmd_o == 3'h4 && cmd_bank_o == $past(bank_select_i, 3))
        else $error("recharge decode or bank wrong");
    a_mode_gap: assert property ($rose(mode_busy_o)
        |-> mode_busy_o[*6] ##1 !mode_busy_o) else $error("mode gap length");
    a_busy_cause: assert property ($rose(mode_busy_o)
        |-> cmd_o == 3'h1) else $error("busy without mode load");
    a_addr_mask: assert property (cmd_o == 3'h2 || cmd_o == 3'h3
        |-> (cmd_addr_o >> cut_w) == 21'h0) else $error("address not masked");
    cover property ($rose(mode_busy_o));
    cover property (wr_store_o);
    cover property ($fell(pll_locked_o));
endmodule : ldcp_checker
bind ldcp_command_port ldcp_checker #(.WIDE(WIDE)) i_ldcp_checker (
    .core_clk_i    (core_clk_i),
    .rst_b_i       (rst_b_i),
    .cs_b_i        (cs_b_i),
    .we_b_i        (we_b_i),
    .recharge_b_i  (recharge_b_i),
    .mode_busy_o   (mode_busy_o),
    .wr_store_o    (wr_store_o),
    .pll_locked_o  (pll_locked_o),
    .address_bus_i (address_bus_i),
    .cmd_addr_o    (cmd_addr_o),
    .bank_select_i (bank_select_i),
    .cmd_o         (cmd_o),
    .cmd_bank_o    (cmd_bank_o),
    .mode_opcode_o (mode_opcode_o),
    .burst_code_o  (burst_code_o)
);

// >>> dv/ldcp_ctrl_model.sv
// controller model: command pins, main clock image, write beats
// assumes its tasks are called from one bench process
`timescale 1ns/1ns
module ldcp_ctrl_model (
    input  wire logic   core_clk_i,
    output logic        cs_b_o, we_b_o, rc_b_o, mclk_o, wclk_o,
    output logic        mask_o, beat_o,
    output logic [20:0] addr_o,
    output logic [2:0]  bank_o,
    output logic [17:0] wdata_o
);
    logic run = 1'b1;
    initial {cs_b_o, we_b_o, rc_b_o, mclk_o, wclk_o, mask_o, beat_o,
             addr_o, bank_o, wdata_o} = {7'h7E, 42'h0};
    always @(posedge core_clk_i) if (run) mclk_o <= ~mclk_o;
    task automatic issue(input logic [2:0] c, input logic [20:0] a,
                         input logic [2:0] b);
        @(posedge core_clk_i) #2;
        {cs_b_o, addr_o, bank_o} = {1'b0, a, b};
        we_b_o = c == 3'h2 || c == 3'h4;
        rc_b_o = c == 3'h2 || c == 3'h3;
        @(posedge core_clk_i) #2;
        // released pins show garbage, not the last value
        {cs_b_o, addr_o, bank_o} = {1'b1, ~a, ~b};
    endtask : issue
    task automatic wbeat(input logic [17:0] d, input logic m);
        {wdata_o, mask_o, beat_o} = {d, m, 1'b1};
        #24 wclk_o = 1'b0;
        #24 wclk_o = 1'b1;
        #2 {wdata_o, beat_o} = {~d, 1'b0};
    endtask : wbeat
endmodule : ldcp_ctrl_model

// >>> dv/tb_top.sv
// bench: controller model against the command port, wide organisation
// assumes clk_en_i held high; lock count shortened to LOCK cycles
`timescale 1ns/1ns
module tb_top;
    localparam int LOCK = 20;
    logic core_clk_i = 1'b0, rst_b_i = 1'b0, clk_en_i = 1'b1;
    logic cs_b_i, we_b_i, recharge_b_i, main_clock_pair_i, wr_beat_i;
    logic write_strobe_clock_i, write_byte_mask_i, pll_locked_o;
    logic mode_busy_o, wr_store_o;
    logic [20:0] address_bus_i, cmd_addr_o;
    logic [2:0]  bank_select_i, cmd_o, cmd_bank_o;
    logic [17:0] wr_data_i, mode_opcode_o, wr_store_data_o, rd_data_i = 18'h0;
    logic [8:0]  rd_lane0_o, rd_lane1_o;
    logic [1:0]  burst_code_o;
    int          n_fail = 0, num_checks = 0, cyc = 0, k;
    always #10 core_clk_i = ~core_clk_i;
    ldcp_ctrl_model i_ldcp_ctrl_model (.core_clk_i, .cs_b_o(cs_b_i),
        .we_b_o(we_b_i), .rc_b_o(recharge_b_i), .mclk_o(main_clock_pair_i),
        .wclk_o(write_strobe_clock_i), .mask_o(write_byte_mask_i),
        .beat_o(wr_beat_i), .addr_o(address_bus_i), .bank_o(bank_select_i),
        .wdata_o(wr_data_i));
    ldcp_command_port #(
        .WIDE                 (1),
        .PLL_LOCK_CYCS        (LOCK)
    ) i_ldcp_command_port (
        .core_clk_i           (core_clk_i),
        .rst_b_i              (rst_b_i),
        .clk_en_i             (clk_en_i),
        .cs_b_i               (cs_b_i),
        .we_b_i               (we_b_i),
        .recharge_b_i         (recharge_b_i),
        .address_bus_i        (address_bus_i),
        .bank_select_i        (bank_select_i),
        .main_clock_pair_i    (main_clock_pair_i),
        .write_strobe_clock_i (write_strobe_clock_i),
        .wr_data_i            (wr_data_i),
        .write_byte_mask_i    (write_byte_mask_i),
        .wr_beat_i            (wr_beat_i),
        .rd_data_i            (rd_data_i),
        .cmd_o                (cmd_o),
        .cmd_bank_o           (cmd_bank_o),
        .cmd_addr_o           (cmd_addr_o),
        .mode_opcode_o        (mode_opcode_o),
        .burst_code_o         (burst_code_o),
        .pll_locked_o         (pll_locked_o),
        .mode_busy_o          (mode_busy_o),
        .wr_store_data_o      (wr_store_data_o),
        .wr_store_o           (wr_store_o),
        .rd_lane0_o           (rd_lane0_o),
        .rd_lane1_o           (rd_lane1_o)
    );
    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report;
        if (n_fail == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            final_report;
        end
    end
    task automatic wait_lock(input int n);
        for (k = 0; k < n && pll_locked_o !== 1'b1; k++)
            @(posedge core_clk_i) #2;
    endtask : wait_lock
    task automatic run_cmd(input logic [2:0] c, input logic [20:0] a,
                           input logic [2:0] b);
        i_ldcp_ctrl_model.issue(c, a, b);
        for (k = 0; k < 8 && cmd_o !== c; k++) @(posedge core_clk_i) #2;
        chk({18'h0, cmd_o}, {18'h0, c});
    endtask : run_cmd
    task automatic t_cmds;
        for (int bl = 0; bl < 4; bl++) begin
            int          eb;
            logic [20:0] ea;
            // code 3 is no burst length; kept at the longest
            eb = (bl > 2) ? 2 : bl;
            ea = 21'h0AAAAA & (21'h1FFFFF >> (eb + 1));
            run_cmd(3'h1, 21'h1C0000 | 21'(bl << 3), 3'h5);
            chk(mode_opcode_o, 21'(bl << 3));
            chk(burst_code_o, 21'(eb));
            for (k = 0; mode_busy_o === 1'b1 && k < 9; k++)
                @(posedge core_clk_i) #2;
            chk(21'(k), 21'h6);
            run_cmd(3'h2, 21'h1FFFFF, 3'(bl));
            chk(cmd_addr_o, 21'h1FFFFF >> (eb + 1));
            chk(cmd_bank_o, 21'(bl));
            run_cmd(3'h3, 21'h0AAAAA, 3'(7 - bl));
            run_cmd(3'h4, 21'h0, 3'h4);
            chk(cmd_addr_o, ea);
            chk(cmd_bank_o, 21'h4);
        end
    endtask : t_cmds
    task automatic t_write;
        i_ldcp_ctrl_model.wbeat(18'h2B3C4, 1'b0);
        for (k = 0; k < 8 && wr_store_o !== 1'b1; k++)
            @(posedge core_clk_i) #2;
        chk(wr_store_o, 1'b1);
        chk(wr_store_data_o, 18'h2B3C4);
        i_ldcp_ctrl_model.wbeat(18'h15A5A, 1'b1);
        repeat (8) @(posedge core_clk_i) #2 chk(wr_store_o, 1'b0);
    endtask : t_write
    task automatic t_read;
        @(posedge core_clk_i) #2 rd_data_i = 18'h2D2A5;
        repeat (3) @(posedge core_clk_i) #2;
        chk(rd_lane0_o, 9'h0A5);
        chk(rd_lane1_o, 9'h169);
    endtask : t_read
    task automatic t_pll;
        wait_lock(LOCK + 10);
        chk(pll_locked_o, 1'b1);
        i_ldcp_ctrl_model.run = 1'b0;
        repeat (6) @(posedge core_clk_i) #2;
        chk(pll_locked_o, 1'b0);
        i_ldcp_ctrl_model.run = 1'b1;
        repeat (10) @(posedge core_clk_i) #2;
        chk(pll_locked_o, 1'b0);
        wait_lock(LOCK + 10);
        chk(pll_locked_o, 1'b1);
    endtask : t_pll
    initial begin
        i_ldcp_ctrl_model.wbeat(18'h0, 1'b1);
        repeat (10) @(posedge core_clk_i);
        #2 rst_b_i = 1'b1;
        t_pll;
        t_cmds;
        t_write;
        t_read;
        final_report;
    end
endmodule : tb_top
